// File: hw/indexer_pkg.sv
`default_nettype none
package indexer_pkg;
  // ----------------------------------------------------------------
  // Widths and encodings
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int OPTYPE_W = 4;
  localparam logic [OPTYPE_W-1:0] OPTYPE_INDEXER = 4'h1;
  localparam logic [WORD_W-1:0] TABLE_FIRST = 16'h0001;
  localparam logic [WORD_W-1:0] TABLE_LAST = 16'h0007;
  localparam logic [WORD_W-1:0] STATION_ONE = 16'h0001;
  localparam logic [WORD_W-1:0] STATION_COUNT_RST = 16'h0008;
  localparam logic [WORD_W-1:0] DELAY_RST = 16'h000A;
  localparam logic [WORD_W-1:0] MOVE_TIME_RST = 16'h0010;
  localparam logic [WORD_W-1:0] POS_RST = 16'h0000;
  localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;
  localparam logic [WORD_W-1:0] ONE_WORD = 16'h0001;

  // ----------------------------------------------------------------
  // Controller register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_TARGET = 4'h1;
  localparam logic [ADDR_W-1:0] REG_TABLE = 4'h2;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h3;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h5;
  localparam int CTRL_MODE_LO = 0;
  localparam int CTRL_MODE_HI = 1;
  localparam int CTRL_REGSEL = 2;
  localparam int CTRL_START = 3;
  localparam int ST_INPOS = 0;
  localparam int ST_DONE = 1;
  localparam int ST_HOMEALM = 2;
  localparam int ST_RANGEWARN = 3;
  localparam int ST_BUSY = 4;
  localparam int IRQ_W = 4;

  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_MOVE = 2'b01,
    DEV_SETTLE = 2'b10
  } dev_state_t;
endpackage
`default_nettype wire

// File: hw/indexer_link_if.sv
`default_nettype none
interface indexer_link_if;
  import indexer_pkg::*;
  logic opModeSelectLow;
  logic opModeSelectHigh;
  logic registerSpeedSpecSelect;
  logic motionStartInput;
  logic [WORD_W-1:0] targetStationWord;
  logic [WORD_W-1:0] tableOrSpeedWord;
  logic motionCompleteFlag;
  logic inPositionFlag;
  logic homeMissingAlarm;
  logic stationRangeWarning;
  modport device (
    input opModeSelectLow, opModeSelectHigh, registerSpeedSpecSelect,
    input motionStartInput, targetStationWord, tableOrSpeedWord,
    output motionCompleteFlag, inPositionFlag, homeMissingAlarm, stationRangeWarning
  );
  modport controller (
    output opModeSelectLow, opModeSelectHigh, registerSpeedSpecSelect,
    output motionStartInput, targetStationWord, tableOrSpeedWord,
    input motionCompleteFlag, inPositionFlag, homeMissingAlarm, stationRangeWarning
  );
endinterface
`default_nettype wire

// File: hw/indexer_drive.sv
// Contract
// - Controller sets operation type to indexer.
// - Auto mode needs both mode selects on.
// - Register data used only with select on.
// - Speed source picks table or direct speed.
// - Station count used; numbering direction ignored.
// - Point table entries one through seven accepted.
// - Direct speed only when two stations occupied.
// - Table move to target station on start.
// - Direct move uses word speed, table one ramps.
// - Start without home raises home alarm.
// - Station above count minus one warns.
// - Start ignored while moving; wait for complete.
// - Controller sets words before start.
// - Post-stop torque limit after delay past in-position.
// - In-position after power-on when on a station.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`default_nettype none
module indexer_drive
  import indexer_pkg::*;
#(
  parameter int W = WORD_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link
  indexer_link_if.device link,
  // Parameters
  input wire logic [OPTYPE_W-1:0] operationTypeParam,
  input wire logic speedSourceParam,
  input wire logic twoStationsOccupied,
  input wire logic [W-1:0] stationCountParam,
  input wire logic stationNumberingDirParam,
  input wire logic [W-1:0] postStopTorqueLimitParam,
  input wire logic [W-1:0] torqueLimitDelayParam,
  input wire logic [W-1:0] normalTorqueLimit,
  input wire logic [W-1:0] moveTimeParam,
  input wire logic homeDone,
  // Motion side
  output logic [W-1:0] moveSpeed_r,
  output logic [W-1:0] rampTableIndex_r,
  output logic [W-1:0] activeStation_r,
  output logic [W-1:0] torqueLimit_r
);
  // ----------------------------------------------------------------
  // Mode and start qualification
  // ----------------------------------------------------------------
  // All qualification is combinational, so a start costs no extra cycle.
  dev_state_t state_r;
  logic startPrev_r;
  logic [W-1:0] timer_r;
  logic [W-1:0] settle_r;
  logic settled_r;
  logic autoMode;
  logic startEdge;
  logic directSpeed;
  logic stationBad;
  logic tableBad;
  logic accept;
  logic idleStart;

  // Range checks on link words share one unsigned comparison.
  function automatic logic outsideRange(input logic [W-1:0] value,
    input logic [W-1:0] lowest, input logic [W-1:0] highest);
    outsideRange = (value < lowest) || (value > highest);
  endfunction

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // Numbering direction has no meaning for the shortest path, so that input stays unread.
  assign autoMode = (operationTypeParam == OPTYPE_INDEXER) && link.opModeSelectLow
    && link.opModeSelectHigh && link.registerSpeedSpecSelect;
  assign directSpeed = speedSourceParam && twoStationsOccupied;
  // A station count of zero wraps the limit, so every station is then accepted.
  assign stationBad = outsideRange(link.targetStationWord, ZERO_WORD,
    stationCountParam - STATION_ONE);
  assign tableBad = !directSpeed
    && outsideRange(link.tableOrSpeedWord, TABLE_FIRST, TABLE_LAST);

  // ----------------------------------------------------------------
  // Start qualification
  // ----------------------------------------------------------------
  // The previous start level resets low, the idle level of the input.
  always_ff @(posedge clk) begin
    if (reset) begin
      startPrev_r <= 1'b0;
    end else begin
      startPrev_r <= link.motionStartInput;
    end
  end

  assign startEdge = link.motionStartInput && !startPrev_r;
  // A busy drive never sees the edge, so a mid-move start is simply dropped.
  assign idleStart = autoMode && startEdge && (state_r == DEV_IDLE);
  // Refused starts leave the drive idle; the flags record home and station refusals, but not a bad table entry.
  assign accept = idleStart && homeDone && !stationBad && !tableBad;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Motion is modelled by a cycle count; real feedback would replace the timer.
  // The settle state gives the flags one clean cycle before the next start.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= DEV_IDLE;
      timer_r <= ZERO_WORD;
    end else begin
      case (state_r)
        DEV_IDLE: begin
          if (accept) begin
            state_r <= DEV_MOVE;
            timer_r <= moveTimeParam;
          end
        end
        DEV_MOVE: begin
          if (timer_r <= ONE_WORD) begin
            state_r <= DEV_SETTLE;
          end else begin
            timer_r <= timer_r - ONE_WORD;
          end
        end
        DEV_SETTLE: begin
          state_r <= DEV_IDLE;
        end
        default: begin
          state_r <= DEV_IDLE;
        end
      endcase
    end
  end

  // Latching at acceptance keeps speed stable even if the master rewrites words.
  always_ff @(posedge clk) begin
    if (reset) begin
      moveSpeed_r <= ZERO_WORD;
      rampTableIndex_r <= TABLE_FIRST;
      activeStation_r <= POS_RST;
    end else if (accept) begin
      activeStation_r <= link.targetStationWord;
      // Direct speed borrows the ramps of the first table entry.
      if (directSpeed) begin
        moveSpeed_r <= link.tableOrSpeedWord;
        rampTableIndex_r <= TABLE_FIRST;
      end else begin
        moveSpeed_r <= ZERO_WORD;
        rampTableIndex_r <= link.tableOrSpeedWord;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  // Alarm and warning reflect the last qualified start attempt.
  // They hold until the next attempt, so software may read them late.
  always_ff @(posedge clk) begin
    if (reset) begin
      link.homeMissingAlarm <= 1'b0;
      link.stationRangeWarning <= 1'b0;
    end else if (idleStart) begin
      link.homeMissingAlarm <= !homeDone;
      link.stationRangeWarning <= stationBad;
    end
  end

  // Reset position lies on station 0, so in-position is on from reset.
  // A new move drops both flags together and settling raises them together.
  always_ff @(posedge clk) begin
    if (reset) begin
      link.inPositionFlag <= 1'b1;
      link.motionCompleteFlag <= 1'b1;
    end else if (accept) begin
      link.inPositionFlag <= 1'b0;
      link.motionCompleteFlag <= 1'b0;
    end else if (state_r == DEV_SETTLE) begin
      link.inPositionFlag <= 1'b1;
      link.motionCompleteFlag <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Torque limit
  // ----------------------------------------------------------------
  // The post-stop limit applies only after the delay, so a settling load is not jerked.
  // The counter stops at the delay, so a long stop never wraps it.
  // Reset clears the limit to zero; the normal limit then applies until the first count ends.
  always_ff @(posedge clk) begin
    if (reset) begin
      settle_r <= ZERO_WORD;
      settled_r <= 1'b0;
      torqueLimit_r <= ZERO_WORD;
    end else if (!link.inPositionFlag) begin
      settle_r <= ZERO_WORD;
      settled_r <= 1'b0;
      torqueLimit_r <= normalTorqueLimit;
    end else if (settle_r >= torqueLimitDelayParam) begin
      settled_r <= 1'b1;
      torqueLimit_r <= postStopTorqueLimitParam;
    end else begin
      settle_r <= settle_r + ONE_WORD;
      torqueLimit_r <= settled_r ? postStopTorqueLimitParam : normalTorqueLimit;
    end
  end
endmodule
`default_nettype wire

// File: hw/indexer_master.sv
`default_nettype none
module indexer_master
  import indexer_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Software port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [WORD_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [WORD_W-1:0] rdata_r,
  output logic irq_r,
  // Link
  indexer_link_if.controller link
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [3:0] ctrl_r;
  logic [WORD_W-1:0] target_r;
  logic [WORD_W-1:0] table_r;
  logic [IRQ_W-1:0] stat_r;
  logic [IRQ_W-1:0] mask_r;
  logic donePrev_r;
  logic inPosPrev_r;
  logic alarmPrev_r;
  logic warnPrev_r;
  logic [IRQ_W-1:0] events;

  // Only rising flags count as events, so a clear sticks while a flag stays high.
  assign events = {link.stationRangeWarning && !warnPrev_r,
    link.homeMissingAlarm && !alarmPrev_r,
    link.motionCompleteFlag && !donePrev_r,
    link.inPositionFlag && !inPosPrev_r};

  // Words and start both go out one cycle after their register write, so software writes the words first.
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= 4'h0;
      target_r <= ZERO_WORD;
      table_r <= TABLE_FIRST;
    end else if (wr) begin
      if (addr == REG_CTRL) begin
        ctrl_r <= wdata[3:0];
      end
      if (addr == REG_TARGET) begin
        target_r <= wdata;
      end
      if (addr == REG_TABLE) begin
        table_r <= wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      link.opModeSelectLow <= 1'b0;
      link.opModeSelectHigh <= 1'b0;
      link.registerSpeedSpecSelect <= 1'b0;
      link.motionStartInput <= 1'b0;
      link.targetStationWord <= ZERO_WORD;
      link.tableOrSpeedWord <= TABLE_FIRST;
      donePrev_r <= 1'b1;
      inPosPrev_r <= 1'b1;
      alarmPrev_r <= 1'b0;
      warnPrev_r <= 1'b0;
    end else begin
      link.opModeSelectLow <= ctrl_r[CTRL_MODE_LO];
      link.opModeSelectHigh <= ctrl_r[CTRL_MODE_HI];
      link.registerSpeedSpecSelect <= ctrl_r[CTRL_REGSEL];
      link.targetStationWord <= target_r;
      link.tableOrSpeedWord <= table_r;
      // Start only while the previous move reported complete.
      link.motionStartInput <= ctrl_r[CTRL_START] && link.motionCompleteFlag;
      donePrev_r <= link.motionCompleteFlag;
      inPosPrev_r <= link.inPositionFlag;
      alarmPrev_r <= link.homeMissingAlarm;
      warnPrev_r <= link.stationRangeWarning;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      stat_r <= 4'h0;
      mask_r <= 4'h0;
      irq_r <= 1'b0;
    end else begin
      stat_r <= events | (stat_r & ~((wr && addr == REG_IRQ_STAT) ? wdata[IRQ_W-1:0] : 4'h0));
      if (wr && addr == REG_IRQ_MASK) begin
        mask_r <= wdata[IRQ_W-1:0];
      end
      irq_r <= |(stat_r & mask_r);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= ZERO_WORD;
    end else if (rd) begin
      case (addr)
        REG_CTRL: rdata_r <= {12'h000, ctrl_r};
        REG_TARGET: rdata_r <= target_r;
        REG_TABLE: rdata_r <= table_r;
        REG_STATUS: rdata_r <= {11'h000, !link.motionCompleteFlag, link.stationRangeWarning,
          link.homeMissingAlarm, link.motionCompleteFlag, link.inPositionFlag};
        REG_IRQ_STAT: rdata_r <= {12'h000, stat_r};
        REG_IRQ_MASK: rdata_r <= {12'h000, mask_r};
        default: rdata_r <= ZERO_WORD;
      endcase
    end else begin
      rdata_r <= ZERO_WORD;
    end
  end
endmodule
`default_nettype wire

// File: tb/indexer_props.sv
`default_nettype none
module indexer_props
  import indexer_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link
  input wire logic opModeSelectLow,
  input wire logic opModeSelectHigh,
  input wire logic registerSpeedSpecSelect,
  input wire logic motionStartInput,
  input wire logic [WORD_W-1:0] targetStationWord,
  input wire logic [WORD_W-1:0] tableOrSpeedWord,
  input wire logic motionCompleteFlag,
  input wire logic inPositionFlag,
  input wire logic homeMissingAlarm,
  input wire logic stationRangeWarning
);
  timeunit 1ns;
  timeprecision 1ps;
  // A generous bound keeps a stuck move visible without tying it to the bench setting.
  localparam int MAXT = 200;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_start_on_done: assert property ($rose(motionStartInput) |-> motionCompleteFlag)
    else $error("start raised while busy");
  a_mode_both_on: assert property ($fell(motionCompleteFlag) |->
    $past(opModeSelectLow) && $past(opModeSelectHigh))
    else $error("move without both mode selects");
  a_regsel_on: assert property ($fell(motionCompleteFlag) |-> $past(registerSpeedSpecSelect))
    else $error("move without register select");
  a_inpos_drops: assert property ($fell(motionCompleteFlag) |-> !inPositionFlag)
    else $error("in-position stayed during move");
  a_busy_bounded: assert property ($fell(motionCompleteFlag) |-> ##[1:MAXT] motionCompleteFlag)
    else $error("move never completed");
  a_busy_min: assert property ($fell(motionCompleteFlag) |-> !motionCompleteFlag [*3])
    else $error("move ended too soon");
  a_home_no_move: assert property ($rose(homeMissingAlarm) |->
    motionCompleteFlag && inPositionFlag)
    else $error("moved with home alarm");
  a_warn_no_move: assert property ($rose(stationRangeWarning) |-> motionCompleteFlag [*2])
    else $error("moved with range warning");
  a_alarm_idle: assert property ((homeMissingAlarm || stationRangeWarning) |->
    motionCompleteFlag)
    else $error("alarm raised during move");
  cover property ($fell(motionCompleteFlag));
  cover property ($rose(homeMissingAlarm));
  cover property ($rose(stationRangeWarning));
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none
module tb_top
  import indexer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] wdata, rdata_r;
  logic wr, rd, irq_r, speedSrc, twoSt, dirSel, homeDone;
  logic [OPTYPE_W-1:0] opType;
  logic [WORD_W-1:0] stCount, postTq, tqDelay, normTq, moveT, speed, ramp, station, torque;
  int failures = 0;
  int compares = 0;
  logic [WORD_W-1:0] rdQ[$];
  logic [48:0] mvQ[$];
  logic [48:0] e;
  logic rdSeen = 1'b0;
  logic doneOld = 1'b1;
  always #5 clk = ~clk;
  indexer_link_if indexer_link_if_i();
  indexer_master indexer_master_i (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_r(rdata_r), .irq_r(irq_r), .link(indexer_link_if_i));
  indexer_drive indexer_drive_i (.clk(clk), .reset(reset), .link(indexer_link_if_i),
    .operationTypeParam(opType), .speedSourceParam(speedSrc), .twoStationsOccupied(twoSt),
    .stationCountParam(stCount), .stationNumberingDirParam(dirSel),
    .postStopTorqueLimitParam(postTq), .torqueLimitDelayParam(tqDelay),
    .normalTorqueLimit(normTq), .moveTimeParam(moveT), .homeDone(homeDone),
    .moveSpeed_r(speed), .rampTableIndex_r(ramp), .activeStation_r(station),
    .torqueLimit_r(torque));
  indexer_props indexer_props_i (.clk(clk), .reset(reset),
    .opModeSelectLow(indexer_link_if_i.opModeSelectLow),
    .opModeSelectHigh(indexer_link_if_i.opModeSelectHigh),
    .registerSpeedSpecSelect(indexer_link_if_i.registerSpeedSpecSelect),
    .motionStartInput(indexer_link_if_i.motionStartInput),
    .targetStationWord(indexer_link_if_i.targetStationWord),
    .tableOrSpeedWord(indexer_link_if_i.tableOrSpeedWord),
    .motionCompleteFlag(indexer_link_if_i.motionCompleteFlag),
    .inPositionFlag(indexer_link_if_i.inPositionFlag),
    .homeMissingAlarm(indexer_link_if_i.homeMissingAlarm),
    .stationRangeWarning(indexer_link_if_i.stationRangeWarning));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrReg(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdReg(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] exp);
    rdQ.push_back(exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // A wait that runs out ends the run at once, so a hung move cannot stall the bench.
  task automatic waitDone(input logic v);
    int n;
    n = 0;
    while (indexer_link_if_i.motionCompleteFlag !== v) begin
      @(posedge clk);
      n++;
      if (n > 300) begin
        failures++;
        summarize();
      end
    end
  endtask
  task automatic tryStart(input logic [WORD_W-1:0] c, tg, st);
    wrReg(REG_TARGET, tg);
    wrReg(REG_CTRL, c);
    repeat (4) @(posedge clk);
    rdReg(REG_STATUS, st);
    wrReg(REG_CTRL, 16'h0007);
  endtask
  task automatic mv(input logic [WORD_W-1:0] tg, tw, input logic dir);
    mvQ.push_back({dir, tg, dir ? ONE_WORD : tw, tw});
    wrReg(REG_TARGET, tg);
    wrReg(REG_TABLE, tw);
    wrReg(REG_CTRL, 16'h000F);
    waitDone(1'b0);
    wrReg(REG_TARGET, tg ^ 16'h0001);
    wrReg(REG_CTRL, 16'h0007);
    wrReg(REG_CTRL, 16'h000F);
    // Start must be low again before the move ends, or the level retriggers.
    wrReg(REG_CTRL, 16'h0007);
    chk(torque, normTq);
    waitDone(1'b1);
    repeat (tqDelay) @(negedge clk);
    chk(torque, normTq);
    repeat (3) @(negedge clk);
    chk(torque, postTq);
  endtask
  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(posedge clk) rdSeen <= rd;
  always @(negedge clk) begin
    if (rdSeen)
      chk(rdata_r, rdQ.pop_front());
    if (indexer_link_if_i.motionCompleteFlag === 1'b1 && doneOld === 1'b0) begin
      if (mvQ.size() == 0) begin
        failures++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, station, 16'h0000);
      end else begin
        e = mvQ.pop_front();
        chk(station, e[47:32]);
        chk(ramp, e[31:16]);
        if (e[48]) chk(speed, e[15:0]);
      end
    end
    doneOld = indexer_link_if_i.motionCompleteFlag;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(41880));
    addr = REG_CTRL;
    wdata = ZERO_WORD;
    wr = 1'b0;
    rd = 1'b0;
    opType = OPTYPE_INDEXER;
    speedSrc = 1'b0;
    twoSt = 1'b1;
    dirSel = 1'b0;
    homeDone = 1'b0;
    stCount = STATION_COUNT_RST;
    postTq = WORD_W'($urandom);
    tqDelay = DELAY_RST;
    normTq = ~postTq;
    moveT = 16'h0028;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rdReg(REG_STATUS, 16'h0003);
    wrReg(REG_IRQ_STAT, 16'h000F);
    wrReg(REG_IRQ_MASK, 16'h000F);
    tryStart(16'h000F, STATION_ONE, 16'h0007);
    homeDone <= 1'b1;
    for (int t = 1; t <= 7; t++) begin
      dirSel <= 1'($urandom);
      mv(t == 7 ? 16'h0007 : WORD_W'($urandom_range(7)), WORD_W'(t), 1'b0);
    end
    rdReg(REG_IRQ_STAT, 16'h0007);
    chk({15'h0000, irq_r}, ONE_WORD);
    wrReg(REG_IRQ_MASK, ZERO_WORD);
    repeat (2) @(posedge clk);
    chk({15'h0000, irq_r}, ZERO_WORD);
    wrReg(REG_IRQ_STAT, 16'h0007);
    wrReg(REG_IRQ_MASK, 16'h000F);
    repeat (2) @(posedge clk);
    chk({15'h0000, irq_r}, ZERO_WORD);
    tryStart(16'h0009, STATION_ONE, 16'h0003);
    tryStart(16'h000A, STATION_ONE, 16'h0003);
    tryStart(16'h000B, STATION_ONE, 16'h0003);
    wrReg(REG_TABLE, TABLE_LAST + ONE_WORD);
    tryStart(16'h000F, STATION_ONE, 16'h0003);
    tryStart(16'h000F, stCount, 16'h000B);
    speedSrc <= 1'b1;
    mv(WORD_W'($urandom_range(7)), WORD_W'($urandom), 1'b1);
    twoSt <= 1'b0;
    mv(16'h0002, 16'h0003, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
